// ===== rtl/scd_clock_control.sv
// Summary of operation
// - Timer clear bit zeroes counter, self-clears
// - Prescaler clear bit zeroes divider, self-clears
// - Dividers fed by selected oscillator enable
// - Bit 7: 0 wake-up allowed, 1 blocked
// - Bits 4:3 select /16, /8, /2, /1
// - Reset selects slowest system clock /16
//
// Implementation choice: the Wishbone interface to the registers.
module scd_clock_control
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_i_unused_n,
  output logic wb_ack_o,
  // Oscillator enables (pins)
  input wire logic main_osc_en,
  input wire logic sub_osc_en,
  // Wake-up request from power-down
  input wire logic irq_req,
  // Outputs
  output logic sys_clk_en,
  output logic clk_out,
  output logic wake_up,
  output logic [7:0] basic_timer_count,
  output logic prescaler_clear
);
  import scd_pkg::*;

  function automatic logic [5:0] sys_term(input logic [1:0] sel);
    unique case (sel)
      2'b00: sys_term = SCD_TC_DIV16;
      2'b01: sys_term = SCD_TC_DIV8;
      2'b10: sys_term = SCD_TC_DIV2;
      2'b11: sys_term = SCD_TC_DIV1;
    endcase
  endfunction

  function automatic logic [5:0] out_term(input logic [1:0] sel);
    unique case (sel)
      2'b00: out_term = SCD_TC_DIV64;
      2'b01: out_term = SCD_TC_DIV16;
      2'b10: out_term = SCD_TC_DIV8;
      2'b11: out_term = SCD_TC_DIV4;
    endcase
  endfunction

  // Pin synchronisers
  logic [1:0] main_s1_q, main_s2_q, irq_s1_q, irq_s2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      main_s1_q <= 2'b00;
      main_s2_q <= 2'b00;
      irq_s1_q <= 2'b00;
      irq_s2_q <= 2'b00;
    end else begin
      main_s1_q <= {sub_osc_en, main_osc_en};
      main_s2_q <= main_s1_q;
      irq_s1_q <= {1'b0, irq_req};
      irq_s2_q <= irq_s1_q;
    end
  end

  // Register and bus state
  scd_bus_state_t bus_q, bus_d;
  logic wake_dis_q, wake_dis_d;
  logic [1:0] sys_div_q, sys_div_d;
  logic [1:0] out_div_q, out_div_d;
  logic osc_sel_q, osc_sel_d;
  logic tmr_clr_q, tmr_clr_d;
  logic pre_clr_q, pre_clr_d;
  logic [7:0] rdat_q, rdat_d;
  logic req;
  logic src_en;
  logic sys_tick, sys_wave, out_tick, out_wave;
  logic [SCD_TIMER_W-1:0] tmr_q, tmr_d;
  logic wake_q, wake_d;
  logic ack_q, ack_d;
  logic spare_q, spare_d;

  assign req = wb_cyc_i && wb_stb_i && (bus_q == SCD_BUS_IDLE);
  // Selected oscillator drives every divider
  assign src_en = osc_sel_q ? main_s2_q[1] : main_s2_q[0];

  always_comb begin
    bus_d = SCD_BUS_IDLE;
    ack_d = 1'b0;
    // Spare pin held high from a flop, no function
    spare_d = 1'b1;
    wake_dis_d = wake_dis_q;
    sys_div_d = sys_div_q;
    out_div_d = out_div_q;
    osc_sel_d = osc_sel_q;
    // Command bits live one cycle only
    tmr_clr_d = 1'b0;
    pre_clr_d = 1'b0;
    rdat_d = rdat_q;
    if (req) begin
      bus_d = SCD_BUS_ACK;
      // Registered ack costs one wait state but keeps stb off any comb path
      ack_d = 1'b1;
      rdat_d = 8'h00;
      unique case (wb_adr_i)
        SCD_ADDR_BASIC_TIMER_CONTROL: begin
          if (wb_we_i) begin
            tmr_clr_d = wb_dat_i[SCD_TMR_CLR_BIT];
            pre_clr_d = wb_dat_i[SCD_PRE_CLR_BIT];
          end
        end
        SCD_ADDR_SYSTEM_CLOCK_CONTROL: begin
          if (wb_we_i) begin
            wake_dis_d = wb_dat_i[SCD_WAKE_IRQ_BIT];
            sys_div_d = wb_dat_i[SCD_SYS_DIV_LSB +: 2];
          end
          rdat_d[SCD_WAKE_IRQ_BIT] = wake_dis_q;
          rdat_d[SCD_SYS_DIV_LSB +: 2] = sys_div_q;
        end
        SCD_ADDR_CLOCK_OUTPUT_CONTROL: begin
          if (wb_we_i) begin
            out_div_d = wb_dat_i[1:0];
          end
          rdat_d[1:0] = out_div_q;
        end
        SCD_ADDR_OSC_SELECT: begin
          if (wb_we_i) begin
            osc_sel_d = wb_dat_i[SCD_OSC_SEL_BIT];
          end
          rdat_d[SCD_OSC_SEL_BIT] = osc_sel_q;
        end
        SCD_ADDR_STATUS: begin
          rdat_d = tmr_q;
        end
        // Unmapped: acked, reads zero, writes dropped
        default: rdat_d = 8'h00;
      endcase
    end
  end

  // Basic timer counter, counts system ticks
  always_comb begin
    tmr_d = tmr_q;
    if (tmr_clr_q) begin
      tmr_d = '0;
    end else if (sys_tick) begin
      tmr_d = tmr_q + 8'h01;
    end
    // Wake-up only when IRQ allowed
    wake_d = irq_s2_q[0] && !wake_dis_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= SCD_BUS_IDLE;
      ack_q <= 1'b0;
      spare_q <= 1'b1;
      wake_dis_q <= SCD_WAKE_IRQ_RST;
      sys_div_q <= SCD_SYS_DIV_RST;
      out_div_q <= SCD_CLK_OUT_RST;
      osc_sel_q <= SCD_OSC_SEL_RST;
      tmr_clr_q <= 1'b0;
      pre_clr_q <= 1'b0;
      rdat_q <= 8'h00;
      tmr_q <= '0;
      wake_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      ack_q <= ack_d;
      spare_q <= spare_d;
      wake_dis_q <= wake_dis_d;
      sys_div_q <= sys_div_d;
      out_div_q <= out_div_d;
      osc_sel_q <= osc_sel_d;
      tmr_clr_q <= tmr_clr_d;
      pre_clr_q <= pre_clr_d;
      rdat_q <= rdat_d;
      tmr_q <= tmr_d;
      wake_q <= wake_d;
    end
  end

  // System clock divider
  scd_divider u_sys_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src_en(src_en),
    .clear(pre_clr_q),
    .term(sys_term(sys_div_q)),
    .tick(sys_tick),
    .wave(sys_wave)
  );

  // Clock output divider
  scd_divider u_out_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src_en(src_en),
    .clear(pre_clr_q),
    .term(out_term(out_div_q)),
    .tick(out_tick),
    .wave(out_wave)
  );

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign wb_ack_i_unused_n = spare_q;
  assign sys_clk_en = sys_tick;
  assign clk_out = out_wave;
  assign wake_up = wake_q;
  assign basic_timer_count = tmr_q;
  assign prescaler_clear = pre_clr_q;

  logic unused_ok;
  assign unused_ok = ^{sys_wave, out_tick, main_s2_q, irq_s2_q[1]};
endmodule

// ===== rtl/scd_divider.sv
module scd_divider (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic src_en,
  input wire logic clear,
  input wire logic [5:0] term,
  // Result
  output logic tick,
  output logic wave
);
  logic [5:0] cnt_q, cnt_d;
  logic tick_q, tick_d, wave_q, wave_d;
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    wave_d = wave_q;
    if (clear) begin
      cnt_d = 6'h00;
      wave_d = 1'b0;
    end else if (src_en) begin
      if (cnt_q >= term) begin
        cnt_d = 6'h00;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 6'h01;
      end
      // Square-ish wave, high in first half of period
      wave_d = (term == 6'h00) ? ~wave_q : (cnt_d <= (term >> 1));
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
      wave_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      wave_q <= wave_d;
    end
  end
  assign tick = tick_q;
  assign wave = wave_q;
endmodule

// ===== rtl/scd_pkg.sv
package scd_pkg;
  // Register byte addresses
  localparam logic [7:0] SCD_ADDR_BASIC_TIMER_CONTROL = 8'hd3;
  localparam logic [7:0] SCD_ADDR_SYSTEM_CLOCK_CONTROL = 8'hd4;
  localparam logic [7:0] SCD_ADDR_CLOCK_OUTPUT_CONTROL = 8'he8;
  localparam logic [7:0] SCD_ADDR_OSC_SELECT = 8'hf0;
  localparam logic [7:0] SCD_ADDR_STATUS = 8'hf4;
  // Field positions
  localparam int SCD_WAKE_IRQ_BIT = 7;
  localparam int SCD_SYS_DIV_LSB = 3;
  localparam int SCD_TMR_CLR_BIT = 1;
  localparam int SCD_PRE_CLR_BIT = 0;
  localparam int SCD_OSC_SEL_BIT = 0;
  // Reset values
  localparam logic SCD_WAKE_IRQ_RST = 1'b0;
  localparam logic [1:0] SCD_SYS_DIV_RST = 2'h0;
  localparam logic [1:0] SCD_CLK_OUT_RST = 2'h0;
  localparam logic SCD_OSC_SEL_RST = 1'b0;
  // Divider ratios as terminal counts (ratio - 1)
  localparam logic [5:0] SCD_TC_DIV64 = 6'h3f;
  localparam logic [5:0] SCD_TC_DIV16 = 6'h0f;
  localparam logic [5:0] SCD_TC_DIV8 = 6'h07;
  localparam logic [5:0] SCD_TC_DIV4 = 6'h03;
  localparam logic [5:0] SCD_TC_DIV2 = 6'h01;
  localparam logic [5:0] SCD_TC_DIV1 = 6'h00;
  localparam int SCD_TIMER_W = 8;
  typedef enum logic [1:0] {
    SCD_BUS_IDLE = 2'b00,
    SCD_BUS_ACK = 2'b01
  } scd_bus_state_t;
endpackage

// ===== sim/scd_clock_control_properties.sv
module scd_clock_control_properties (
  // Clock and bus
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Pins
  input wire logic main_osc_en,
  input wire logic sub_osc_en,
  input wire logic irq_req,
  input wire logic sys_clk_en,
  input wire logic clk_out,
  input wire logic wake_up,
  input wire logic [7:0] basic_timer_count,
  input wire logic prescaler_clear
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic wr;
  logic c_q;
  logic w4_q;
  logic [1:0] div_q;
  logic [1:0] clo_q;
  logic [7:0] ok_q;
  logic [7:0] g_q;
  logic [7:0] h_q;
  assign wr = wb_ack_o && wb_we_i;
  // Periods judged only after 200 quiet cycles, so first periods after a write are free
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {c_q, w4_q, div_q, clo_q, ok_q, g_q, h_q} <= '0;
    end else begin
      div_q <= (wr && wb_adr_i == 8'hd4) ? wb_dat_i[4:3] : div_q;
      clo_q <= (wr && wb_adr_i == 8'he8) ? wb_dat_i[1:0] : clo_q;
      w4_q <= w4_q | (wr && wb_adr_i == 8'hd4);
      ok_q <= (wr || !main_osc_en) ? 8'h00 : (ok_q == 8'hc8 ? ok_q : ok_q + 8'h01);
      g_q <= sys_clk_en ? 8'h00 : g_q + 8'h01;
      h_q <= (clk_out != c_q) ? 8'h00 : h_q + 8'h01;
      c_q <= clk_out;
    end
  end
  tmr_clear_a: assert property (wr && wb_adr_i == 8'hd3 && wb_dat_i[1] |-> ##[0:3] basic_timer_count == 8'h00)
    else $error("timer count not cleared");
  pre_clear_a: assert property (wr && wb_adr_i == 8'hd3 && wb_dat_i[0] |-> ##[0:3] prescaler_clear ##1 !prescaler_clear)
    else $error("prescaler clear pulse wrong");
  osc_gate_a: assert property ((!main_osc_en && !sub_osc_en) [*6] |=> !sys_clk_en)
    else $error("system clock runs without oscillator");
  wake_gate_a: assert property (!irq_req [*4] |=> !wake_up)
    else $error("wake-up without request");
  sys_ratio_a: assert property (sys_clk_en && ok_q == 8'hc8 |->
    g_q == (div_q == 2'h0 ? 8'h0f : div_q == 2'h1 ? 8'h07 : {7'h00, !div_q[0]}))
    else $error("system clock period wrong");
  slow_reset_a: assert property (sys_clk_en && ok_q == 8'hc8 && !w4_q |-> g_q == 8'h0f)
    else $error("reset system clock not slowest");
  out_ratio_a: assert property (clk_out != c_q && ok_q == 8'hc8 |->
    h_q == (clo_q == 2'h0 ? 8'h1f : clo_q == 2'h1 ? 8'h07 : clo_q == 2'h2 ? 8'h03 : 8'h01))
    else $error("clock output half period wrong");
  cover property (sys_clk_en && div_q == 2'h3);
  cover property (prescaler_clear);
  cover property (wake_up);
endmodule

// ===== sim/scd_clock_control_tb_top.sv
module scd_clock_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_n, cyc, stb, we, ack, main_osc_en, sub_osc_en, irq_req, spare;
  logic sys_clk_en, clk_out, wake_up, pclr, clk_q;
  logic [7:0] adr, wdat, rdat, tcount, r;
  int n_errors, checks_done;
  int n_ticks, n_tog, n_pclr, t0, t1;
  // Events per 128 cycles for each divider setting
  logic [7:0] sys_exp [4] = '{8'h08, 8'h10, 8'h40, 8'h80};
  logic [7:0] out_exp [4] = '{8'h04, 8'h10, 8'h20, 8'h40};
  always @(posedge ref_clk) begin
    clk_q <= clk_out;
    if (sys_clk_en === 1'b1) n_ticks <= n_ticks + 1;
    if (clk_out !== clk_q) n_tog <= n_tog + 1;
    if (pclr === 1'b1) n_pclr <= n_pclr + 1;
  end
  scd_clock_control dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_i_unused_n(spare), .wb_ack_o(ack),
    .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en), .irq_req(irq_req), .sys_clk_en(sys_clk_en),
    .clk_out(clk_out), .wake_up(wake_up), .basic_timer_count(tcount), .prescaler_clear(pclr));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Bus cycle held until ack is sampled at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    test_done;
  end
  initial begin
    {cyc, stb, we, adr, wdat, irq_req, rst_n, sub_osc_en} = '0;
    main_osc_en = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Long idle lets the reset dividers be judged
    repeat (260) @(posedge ref_clk);
    wb(1'b0, 8'hd4, 8'h00);
    chk("sysctl", r, 8'h00);
    wb(1'b0, 8'he8, 8'h00);
    chk("outctl", r, 8'h00);
    chk("spare", {7'h00, spare}, 8'h01);
    chk("wake idle", {7'h00, wake_up}, 8'h00);
    irq_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("wake on", {7'h00, wake_up}, 8'h01);
    wb(1'b1, 8'hd4, 8'h80);
    repeat (4) @(posedge ref_clk);
    chk("wake blocked", {7'h00, wake_up}, 8'h00);
    wb(1'b0, 8'h10, 8'h00);
    chk("unmapped", r, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'hd4, {3'h0, i[1:0], 3'h0});
      wb(1'b1, 8'he8, {6'h00, i[1:0]});
      wb(1'b0, 8'hd4, 8'h00);
      chk("sysdiv", r, {3'h0, i[1:0], 3'h0});
      wb(1'b0, 8'he8, 8'h00);
      chk("outsel", r, {6'h00, i[1:0]});
      repeat (260) @(posedge ref_clk);
      t0 = n_ticks;
      t1 = n_tog;
      repeat (128) @(posedge ref_clk);
      chk("sys ticks", 8'(n_ticks - t0), sys_exp[i]);
      chk("out toggles", 8'(n_tog - t1), out_exp[i]);
    end
    wb(1'b1, 8'hd3, 8'h03);
    wb(1'b0, 8'hd3, 8'h00);
    chk("cmd bits", r, 8'h00);
    chk("pclr pulses", n_pclr[7:0], 8'h01);
    // Sub selected while only main runs: no ticks
    wb(1'b1, 8'hf0, 8'h01);
    wb(1'b0, 8'hf0, 8'h00);
    chk("osc sel", r, 8'h01);
    repeat (4) @(posedge ref_clk);
    t0 = n_ticks;
    repeat (128) @(posedge ref_clk);
    chk("sub idle ticks", 8'(n_ticks - t0), 8'h00);
    main_osc_en <= 1'b0;
    sub_osc_en <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t0 = n_ticks;
    repeat (128) @(posedge ref_clk);
    chk("sub ticks", 8'(n_ticks - t0), 8'h80);
    sub_osc_en <= 1'b0;
    repeat (6) @(posedge ref_clk);
    wb(1'b1, 8'hd3, 8'h02);
    chk("pclr kept", n_pclr[7:0], 8'h01);
    wb(1'b0, 8'hf4, 8'h00);
    chk("timer cleared", r, 8'h00);
    sub_osc_en <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sub_osc_en <= 1'b0;
    repeat (6) @(posedge ref_clk);
    wb(1'b0, 8'hf4, 8'h00);
    chk("timer count", r, 8'h05);
    chk("timer pins", tcount, 8'h05);
    wb(1'b1, 8'hf0, 8'h00);
    t0 = n_ticks;
    repeat (20) @(posedge ref_clk);
    chk("no osc ticks", 8'(n_ticks - t0), 8'h00);
    main_osc_en <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    wb(1'b0, 8'hd4, 8'h00);
    chk("sysctl reset", r, 8'h00);
    t0 = n_ticks;
    repeat (128) @(posedge ref_clk);
    chk("reset ticks", 8'(n_ticks - t0), 8'h08);
    test_done;
  end
endmodule
bind scd_clock_control scd_clock_control_properties chk_i (.ref_clk, .rst_n, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_ack_o, .main_osc_en, .sub_osc_en, .irq_req, .sys_clk_en, .clk_out, .wake_up, .basic_timer_count,
  .prescaler_clear);
